// File: pkg/uart_port_pkg.sv
`default_nettype none
package uart_port_pkg;
    // Serial channel register select codes
    localparam logic [2:0] REG_RX_TX      = 3'h0;
    localparam logic [2:0] REG_IRQ_EN     = 3'h1;
    localparam logic [2:0] REG_IRQ_ID     = 3'h2;
    localparam logic [2:0] REG_LINE_CTRL  = 3'h3;
    localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
    localparam logic [2:0] REG_LINE_STAT  = 3'h5;
    localparam logic [2:0] REG_MODEM_STAT = 3'h6;
    localparam logic [2:0] REG_SCRATCH    = 3'h7;
    // Printer port register select codes
    localparam logic [2:0] PP_DATA        = 3'h0;
    localparam logic [2:0] PP_STATUS      = 3'h1;
    localparam logic [2:0] PP_CTRL        = 3'h2;
    // Field positions
    localparam int DIVISOR_ACCESS_BIT = 7;
    localparam int IER_MODEM_BIT      = 3;
    localparam int MCR_DTR_BIT        = 0;
    localparam int MCR_RTS_BIT        = 1;
    localparam int MCR_LOOP_BIT       = 4;
    // Reset and fixed values
    localparam logic [7:0]  LCR_RST     = 8'h00;
    localparam logic [3:0]  IER_RST     = 4'h0;
    localparam logic [4:0]  MCR_RST     = 5'h00;
    localparam logic [7:0]  SCR_RST     = 8'h00;
    localparam logic [3:0]  FLAGS_RST   = 4'h0;
    localparam logic [7:0]  PP_DATA_RST = 8'h00;
    localparam logic [7:0]  PP_CTRL_RST = 8'hE0;
    localparam logic [7:0]  LSR_IDLE    = 8'h60;
    localparam logic [7:0]  RX_EMPTY    = 8'h00;
    localparam logic [7:0]  PP_STAT_VAL = 8'h00;
    localparam logic [7:0]  BUS_IDLE    = 8'hFF;
    localparam logic [15:0] PIN_IDLE    = 16'hF800;
    localparam logic [7:0]  MODEM_IDLE  = 8'hFF;
    // Access targets
    typedef enum logic [1:0]
    {
        TGT_SERIAL0 = 2'b00,
        TGT_SERIAL1 = 2'b01,
        TGT_PRINTER = 2'b10
    } target_type;
    // Host strobe timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 30;
    localparam int STROBE_NS     = 80;
    localparam int HOLD_NS       = 30;
    localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_LAST  = 4'(SETUP_CYC - 1);
    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
    localparam logic [3:0] HOLD_LAST   = 4'(HOLD_CYC - 1);
    // Host AXI4-Lite map and fields
    localparam logic [7:0] CMD_OFFSET    = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int CMD_ADDR_LSB   = 0;
    localparam int CMD_TGT_LSB    = 3;
    localparam int CMD_WRITE_BIT  = 5;
    localparam int CMD_WDATA_LSB  = 8;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_RDATA_LSB = 8;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage
`default_nettype wire

// File: pkg/host_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
    logic       serial0_select_n;
    logic       serial1_select_n;
    logic       printer_port_select_n;
    logic       host_read_strobe_n;
    logic       host_write_strobe_n;
    logic [2:0] register_select_bits;
    logic [7:0] host_data;
    logic       host_data_oe_n;
    logic [7:0] dev_data;
    logic       dev_data_oe_n;
    logic [7:0] data_bus;

    // Shared data bus level, pulled high when undriven
    assign data_bus = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : uart_port_pkg::BUS_IDLE);

    modport device_end
    (
        input  serial0_select_n, serial1_select_n, printer_port_select_n,
        input  host_read_strobe_n, host_write_strobe_n, register_select_bits, data_bus,
        output dev_data, dev_data_oe_n
    );
    modport host_end
    (
        output serial0_select_n, serial1_select_n, printer_port_select_n,
        output host_read_strobe_n, host_write_strobe_n, register_select_bits,
        output host_data, host_data_oe_n,
        input  data_bus
    );
endinterface
`default_nettype wire

// File: rtl/uart_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module uart_host_port
(
    input  wire logic           aclk,
    input  wire logic           aresetn,
    host_port_if.device_end     bus,
    input  wire logic [1:0]     clear_to_send_n,
    input  wire logic [1:0]     peer_set_ready_n,
    input  wire logic [1:0]     carrier_detect_n,
    input  wire logic [1:0]     call_alert_n,
    output logic      [1:0]     chan_irq,
    output logic      [1:0]     terminal_ready_n,
    output logic      [1:0]     send_request_n,
    output logic      [7:0]     printer_data,
    output logic      [7:0]     printer_ctrl
);
    import uart_port_pkg::*;

    logic [15:0] pin_meta_ff;
    logic [15:0] pin_sync_ff;
    logic [1:0]  strobe_prev_ff;
    logic [7:0]  modem_meta_ff;
    logic [7:0]  modem_sync_ff;
    logic [7:0]  modem_prev_ff;
    logic [2:0]  sel_s;
    logic        rd_s;
    logic        wr_s;
    logic [2:0]  addr_s;
    logic [7:0]  data_s;
    logic        rd_active;
    logic        rd_end;
    logic        wr_end;
    logic [7:0]  lcr_ff [2];
    logic [3:0]  ier_ff [2];
    logic [4:0]  mcr_ff [2];
    logic [7:0]  scr_ff [2];
    logic [7:0]  thr_ff [2];
    logic [7:0]  dll_ff [2];
    logic [7:0]  dlm_ff [2];
    logic [3:0]  flags_ff [2];
    logic [1:0]  irq_ff;
    logic [7:0]  pp_data_ff;
    logic [7:0]  pp_ctrl_ff;
    logic [7:0]  rd_data_ff;
    logic [3:0]  lvl [2];
    logic [3:0]  chg [2];
    logic [7:0]  chan_rd [2];
    logic [7:0]  nxt_rd_data;

    // Pin sampling: selects, strobes, address, data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_ff    <= PIN_IDLE;
            pin_sync_ff    <= PIN_IDLE;
            strobe_prev_ff <= 2'b11;
        end
        else
        begin
            pin_meta_ff    <= {bus.printer_port_select_n, bus.serial1_select_n, bus.serial0_select_n,
                               bus.host_read_strobe_n, bus.host_write_strobe_n,
                               bus.register_select_bits, bus.data_bus};
            pin_sync_ff    <= pin_meta_ff;
            strobe_prev_ff <= pin_sync_ff[12:11];
        end
    end

    // Modem inputs: no reset so levels track during reset
    always_ff @(posedge aclk)
    begin
        modem_meta_ff <= {call_alert_n[1], carrier_detect_n[1], peer_set_ready_n[1], clear_to_send_n[1],
                          call_alert_n[0], carrier_detect_n[0], peer_set_ready_n[0], clear_to_send_n[0]};
        modem_sync_ff <= modem_meta_ff;
        modem_prev_ff <= modem_sync_ff;
    end

    // Decoded synchronised access
    assign sel_s     = pin_sync_ff[15:13];
    assign rd_s      = pin_sync_ff[12];
    assign wr_s      = pin_sync_ff[11];
    assign addr_s    = pin_sync_ff[10:8];
    assign data_s    = pin_sync_ff[7:0];
    assign rd_active = !rd_s && (sel_s != 3'b111);
    assign rd_end    = rd_s && !strobe_prev_ff[1];
    assign wr_end    = wr_s && !strobe_prev_ff[0];

    // Per channel levels and edges, nibble order ri, dcd, dsr, cts
    always_comb
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            lvl[ch]    = ~modem_sync_ff[4*ch +: 4];
            chg[ch][0] = modem_sync_ff[4*ch]     ^ modem_prev_ff[4*ch];
            chg[ch][1] = modem_sync_ff[4*ch + 1] ^ modem_prev_ff[4*ch + 1];
            chg[ch][3] = modem_sync_ff[4*ch + 2] ^ modem_prev_ff[4*ch + 2];
            chg[ch][2] = modem_sync_ff[4*ch + 3] & ~modem_prev_ff[4*ch + 3];
        end
    end

    // Change flags: set wins over the clear at read end
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
                flags_ff[ch] <= FLAGS_RST;
            else if (rd_end && !sel_s[ch] && addr_s == REG_MODEM_STAT)
                flags_ff[ch] <= chg[ch];
            else
                flags_ff[ch] <= flags_ff[ch] | chg[ch];
        end
    end

    // Channel interrupt from pending modem changes only
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
                irq_ff[ch] <= 1'b0;
            else
                irq_ff[ch] <= ier_ff[ch][IER_MODEM_BIT] && (flags_ff[ch] != FLAGS_RST);
        end
    end

    // Control registers cleared by reset
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
            begin
                lcr_ff[ch] <= LCR_RST;
                ier_ff[ch] <= IER_RST;
                mcr_ff[ch] <= MCR_RST;
                scr_ff[ch] <= SCR_RST;
            end
            else if (wr_end && !sel_s[ch])
            begin
                case (addr_s)
                    REG_IRQ_EN:
                        if (!lcr_ff[ch][DIVISOR_ACCESS_BIT])
                            ier_ff[ch] <= data_s[3:0];
                    REG_LINE_CTRL:  lcr_ff[ch] <= data_s;
                    REG_MODEM_CTRL: mcr_ff[ch] <= data_s[4:0];
                    REG_SCRATCH:    scr_ff[ch] <= data_s;
                    default:        ;
                endcase
            end
        end
    end

    // Holding and divisor latches survive reset
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (wr_end && !sel_s[ch] && addr_s == REG_RX_TX)
            begin
                if (lcr_ff[ch][DIVISOR_ACCESS_BIT])
                    dll_ff[ch] <= data_s;
                else
                    thr_ff[ch] <= data_s;
            end
            if (wr_end && !sel_s[ch] && addr_s == REG_IRQ_EN && lcr_ff[ch][DIVISOR_ACCESS_BIT])
                dlm_ff[ch] <= data_s;
        end
    end

    // Printer port registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pp_data_ff <= PP_DATA_RST;
            pp_ctrl_ff <= PP_CTRL_RST;
        end
        else if (wr_end && !sel_s[2])
        begin
            if (addr_s == PP_DATA)
                pp_data_ff <= data_s;
            if (addr_s == PP_CTRL)
                pp_ctrl_ff <= data_s;
        end
    end

    // Channel read view
    always_comb
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            case (addr_s)
                REG_RX_TX:      chan_rd[ch] = lcr_ff[ch][DIVISOR_ACCESS_BIT] ? dll_ff[ch] : RX_EMPTY;
                REG_IRQ_EN:     chan_rd[ch] = lcr_ff[ch][DIVISOR_ACCESS_BIT] ? dlm_ff[ch] : {4'h0, ier_ff[ch]};
                REG_IRQ_ID:     chan_rd[ch] = {7'h00, !irq_ff[ch]};
                REG_LINE_CTRL:  chan_rd[ch] = lcr_ff[ch];
                REG_MODEM_CTRL: chan_rd[ch] = {3'h0, mcr_ff[ch]};
                REG_LINE_STAT:  chan_rd[ch] = LSR_IDLE;
                REG_MODEM_STAT: chan_rd[ch] = {lvl[ch][2], lvl[ch][3], lvl[ch][1], lvl[ch][0], flags_ff[ch]};
                default:        chan_rd[ch] = scr_ff[ch];
            endcase
        end
    end

    // Target choice, serial 0 first if several are selected
    always_comb
    begin
        nxt_rd_data = BUS_IDLE;
        if (!sel_s[0])
            nxt_rd_data = chan_rd[0];
        else if (!sel_s[1])
            nxt_rd_data = chan_rd[1];
        else if (!sel_s[2])
        begin
            case (addr_s)
                PP_DATA:   nxt_rd_data = pp_data_ff;
                PP_STATUS: nxt_rd_data = PP_STAT_VAL;
                PP_CTRL:   nxt_rd_data = pp_ctrl_ff;
                default:   nxt_rd_data = BUS_IDLE;
            endcase
        end
    end

    // Read data register follows the addressed register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rd_data_ff <= BUS_IDLE;
        else if (rd_active)
            rd_data_ff <= nxt_rd_data;
    end

    // Bus drive while read strobe and a select are low
    assign bus.dev_data      = rd_data_ff;
    assign bus.dev_data_oe_n = !rd_active;

    // Modem outputs; loop mode holds them inactive
    always_comb
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            terminal_ready_n[ch] = !(mcr_ff[ch][MCR_DTR_BIT] && !mcr_ff[ch][MCR_LOOP_BIT]);
            send_request_n[ch]   = !(mcr_ff[ch][MCR_RTS_BIT] && !mcr_ff[ch][MCR_LOOP_BIT]);
        end
    end

    // Modem status feeds status and interrupt only
    assign chan_irq     = irq_ff;
    assign printer_data = pp_data_ff;
    assign printer_ctrl = pp_ctrl_ff;
endmodule
`default_nettype wire

// File: rtl/uart_host_master.sv
`timescale 1ns/100ps
`default_nettype none
module uart_host_master
(
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic [7:0]     s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic      [1:0]     s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire logic [7:0]     s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic      [31:0]    s_axi_rdata,
    output logic      [1:0]     s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    host_port_if.host_end       port
);
    import uart_port_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_SETUP  = 2'b01,
        ST_STROBE = 2'b10,
        ST_HOLD   = 2'b11
    } host_state_type;

    host_state_type state_ff;
    logic [3:0]     cnt_ff;
    logic           aw_got_ff;
    logic           w_got_ff;
    logic [7:0]     awaddr_ff;
    logic [31:0]    wdata_ff;
    logic [3:0]     wstrb_ff;
    logic [1:0]     bresp_ff;
    logic           bvalid_ff;
    logic [31:0]    rdata_ff;
    logic [1:0]     rresp_ff;
    logic           rvalid_ff;
    logic           start;
    logic [2:0]     sel_n_ff;
    logic           rd_n_ff;
    logic           wr_n_ff;
    logic           write_ff;
    logic [2:0]     addr_ff;
    logic [7:0]     hdata_ff;
    logic           hdata_oe_n_ff;
    logic [7:0]     dbus_meta_ff;
    logic [7:0]     dbus_sync_ff;
    logic [7:0]     last_rd_ff;

    // Write channel acceptance in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign start = aw_got_ff && w_got_ff && !bvalid_ff && awaddr_ff == CMD_OFFSET
                   && wstrb_ff[0] && state_ff == ST_IDLE;

    // AXI write path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= AXI_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (aw_got_ff && w_got_ff && !bvalid_ff)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (awaddr_ff == CMD_OFFSET || awaddr_ff == STATUS_OFFSET) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // AXI read path, one cycle answer
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= AXI_OKAY;
            rdata_ff  <= 32'h0000_0000;
            if (s_axi_araddr == STATUS_OFFSET)
                rdata_ff <= {16'h0000, last_rd_ff, 7'h00, state_ff != ST_IDLE};
            else if (s_axi_araddr != CMD_OFFSET)
                rresp_ff <= AXI_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    // Data bus sampled through two flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dbus_meta_ff <= BUS_IDLE;
            dbus_sync_ff <= BUS_IDLE;
        end
        else
        begin
            dbus_meta_ff <= port.data_bus;
            dbus_sync_ff <= dbus_meta_ff;
        end
    end

    // Strobe sequencer: setup, strobe, hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= 4'h0;
            sel_n_ff      <= 3'b111;
            rd_n_ff       <= 1'b1;
            wr_n_ff       <= 1'b1;
            write_ff      <= 1'b0;
            addr_ff       <= 3'h0;
            hdata_ff      <= 8'h00;
            hdata_oe_n_ff <= 1'b1;
            last_rd_ff    <= 8'h00;
        end
        else
        begin
            cnt_ff <= cnt_ff + 4'h1;
            unique case (state_ff)
                ST_IDLE:
                    if (start)
                    begin
                        state_ff      <= ST_SETUP;
                        cnt_ff        <= 4'h0;
                        addr_ff       <= wdata_ff[CMD_ADDR_LSB +: 3];
                        write_ff      <= wdata_ff[CMD_WRITE_BIT];
                        hdata_ff      <= wdata_ff[CMD_WDATA_LSB +: 8];
                        hdata_oe_n_ff <= !wdata_ff[CMD_WRITE_BIT];
                        sel_n_ff      <= ~(3'b001 << wdata_ff[CMD_TGT_LSB +: 2]);
                    end
                ST_SETUP:
                    if (cnt_ff == SETUP_LAST)
                    begin
                        state_ff <= ST_STROBE;
                        cnt_ff   <= 4'h0;
                        rd_n_ff  <= write_ff;
                        wr_n_ff  <= !write_ff;
                    end
                ST_STROBE:
                    if (cnt_ff == STROBE_LAST)
                    begin
                        state_ff <= ST_HOLD;
                        cnt_ff   <= 4'h0;
                        rd_n_ff  <= 1'b1;
                        wr_n_ff  <= 1'b1;
                        if (!write_ff)
                            last_rd_ff <= dbus_sync_ff;
                    end
                ST_HOLD:
                    if (cnt_ff == HOLD_LAST)
                    begin
                        state_ff      <= ST_IDLE;
                        sel_n_ff      <= 3'b111;
                        hdata_oe_n_ff <= 1'b1;
                    end
            endcase
        end
    end

    // Port pins
    assign port.serial0_select_n      = sel_n_ff[0];
    assign port.serial1_select_n      = sel_n_ff[1];
    assign port.printer_port_select_n = sel_n_ff[2];
    assign port.host_read_strobe_n    = rd_n_ff;
    assign port.host_write_strobe_n   = wr_n_ff;
    assign port.register_select_bits  = addr_ff;
    assign port.host_data             = hdata_ff;
    assign port.host_data_oe_n        = hdata_oe_n_ff;
endmodule
`default_nettype wire

// File: bench/uart_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module uart_port_asserts
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       serial0_select_n,
    input wire logic       serial1_select_n,
    input wire logic       printer_port_select_n,
    input wire logic       host_read_strobe_n,
    input wire logic       host_write_strobe_n,
    input wire logic       host_data_oe_n,
    input wire logic [7:0] dev_data,
    input wire logic       dev_data_oe_n
);
    // Short aliases for strobes, drive and select
    wire logic rd_n = host_read_strobe_n;
    wire logic wr_n = host_write_strobe_n;
    wire logic oe_n = dev_data_oe_n;
    wire logic any_sel = !(serial0_select_n && serial1_select_n && printer_port_select_n);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_idle: assert property ($rose(aresetn) |-> oe_n && rd_n && wr_n)
        else $error("bus not idle after reset");
    a_read_selected: assert property ($fell(rd_n) |-> any_sel && $past(any_sel, 2))
        else $error("read strobe without select setup");
    a_strobe_width: assert property ($fell(rd_n) |-> !rd_n [*8] ##1 rd_n)
        else $error("read strobe width wrong");
    a_select_hold: assert property ($rose(rd_n) |-> any_sel [*3] ##1 !any_sel)
        else $error("select hold wrong");
    a_write_drive: assert property (!wr_n |-> !host_data_oe_n && oe_n)
        else $error("write without host drive");
    a_single_drive: assert property (!oe_n |-> host_data_oe_n && any_sel)
        else $error("device drives outside a read");
    a_drive_cause: assert property ($fell(oe_n) |-> !$past(rd_n, 2))
        else $error("device drive without synced read");
    a_data_steady: assert property (!oe_n && !$past(oe_n, 2) |-> $stable(dev_data))
        else $error("read data moved");
    a_drive_release: assert property ($rose(rd_n) |-> ##[1:3] oe_n)
        else $error("device kept driving");
    a_one_strobe: assert property (rd_n || wr_n)
        else $error("both strobes low");
    c_read: cover property ($fell(rd_n));
    c_write: cover property ($fell(wr_n));
    c_drive: cover property ($fell(oe_n));
endmodule
`default_nettype wire

// File: bench/dual_uart_host_port_modem_status_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_uart_host_port_modem_status_test;
    import uart_port_pkg::*;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, q, printer_data, printer_ctrl;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, word;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, chan_irq, terminal_ready_n, send_request_n, resp;
    logic [1:0]  clear_to_send_n = 2'b10, peer_set_ready_n = 2'b11, carrier_detect_n = 2'b11, call_alert_n = 2'b11;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    host_port_if port_bus ();
    uart_host_master u_uart_host_master (.*, .port(port_bus));
    uart_host_port u_uart_host_port (.*, .bus(port_bus));
    uart_port_asserts u_uart_port_asserts
    (
        .aclk(aclk), .aresetn(aresetn), .serial0_select_n(port_bus.serial0_select_n),
        .serial1_select_n(port_bus.serial1_select_n), .printer_port_select_n(port_bus.printer_port_select_n),
        .host_read_strobe_n(port_bus.host_read_strobe_n), .host_write_strobe_n(port_bus.host_write_strobe_n),
        .host_data_oe_n(port_bus.host_data_oe_n), .dev_data(port_bus.dev_data), .dev_data_oe_n(port_bus.dev_data_oe_n)
    );
    // Clock and hang guard
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bus write, both halves offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        fork
            begin do @(posedge aclk); while (s_axi_awready !== 1); s_axi_awvalid <= 0; end
            begin do @(posedge aclk); while (s_axi_wready !== 1); s_axi_wvalid <= 0; end
        join
        while (s_axi_bvalid !== 1) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1) @(posedge aclk);
        word = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // One port access, waits until the sequencer is idle
    task automatic po(input logic [4:0] tr, input logic w, input logic [7:0] d);
        axw(CMD_OFFSET, {16'h0, d, 2'b0, w, tr});
        `CHK(resp, AXI_OKAY)
        do axr(STATUS_OFFSET); while (word[STAT_BUSY_BIT] !== 1'b0);
        `CHK(resp, AXI_OKAY)
        q = word[15:8];
    endtask
    task automatic rd(input logic [4:0] tr, input logic [7:0] e);
        po(tr, 1'b0, 8'h00);
        `CHK(q, e)
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd({TGT_SERIAL0, REG_MODEM_STAT}, 8'h10);
        `CHK(printer_ctrl, PP_CTRL_RST)
        {carrier_detect_n[0], call_alert_n[0], peer_set_ready_n[0], clear_to_send_n[0]} <= 4'h0;
        rd({TGT_SERIAL0, REG_MODEM_STAT}, 8'hFA);
        rd({TGT_SERIAL0, REG_MODEM_STAT}, 8'hF0);
        {carrier_detect_n[0], call_alert_n[0], peer_set_ready_n[0], clear_to_send_n[0]} <= 4'hF;
        rd({TGT_SERIAL0, REG_MODEM_STAT}, 8'h0F);
        rd({TGT_SERIAL1, REG_MODEM_STAT}, 8'h00);
        $display("test modem status done");
        po({TGT_SERIAL1, REG_IRQ_EN}, 1'b1, 8'h08);
        call_alert_n[1] <= 0;
        repeat (5) @(posedge aclk);
        `CHK(chan_irq, 2'b00)
        call_alert_n[1] <= 1;
        repeat (5) @(posedge aclk);
        `CHK(chan_irq, 2'b10)
        rd({TGT_SERIAL1, REG_MODEM_STAT}, 8'h04);
        `CHK(chan_irq, 2'b00)
        peer_set_ready_n[1] <= 0;
        repeat (5) @(posedge aclk);
        `CHK(chan_irq, 2'b10)
        rd({TGT_SERIAL1, REG_IRQ_ID}, 8'h00);
        rd({TGT_SERIAL1, REG_MODEM_STAT}, 8'h22);
        $display("test interrupt done");
        po({TGT_SERIAL0, REG_SCRATCH}, 1'b1, 8'hA5);
        po({TGT_SERIAL1, REG_SCRATCH}, 1'b1, 8'h3C);
        rd({TGT_SERIAL0, REG_SCRATCH}, 8'hA5);
        rd({TGT_SERIAL1, REG_SCRATCH}, 8'h3C);
        po({TGT_SERIAL0, REG_LINE_CTRL}, 1'b1, 8'h80);
        po({TGT_SERIAL0, REG_RX_TX}, 1'b1, 8'h12);
        po({TGT_SERIAL0, REG_IRQ_EN}, 1'b1, 8'h34);
        rd({TGT_SERIAL0, REG_RX_TX}, 8'h12);
        rd({TGT_SERIAL0, REG_IRQ_EN}, 8'h34);
        po({TGT_SERIAL0, REG_LINE_CTRL}, 1'b1, 8'h00);
        rd({TGT_SERIAL0, REG_RX_TX}, RX_EMPTY);
        rd({TGT_SERIAL0, REG_IRQ_EN}, 8'h00);
        rd({TGT_SERIAL0, REG_LINE_STAT}, LSR_IDLE);
        po({TGT_PRINTER, PP_DATA}, 1'b1, 8'h5A);
        `CHK(printer_data, 8'h5A)
        rd({TGT_PRINTER, PP_DATA}, 8'h5A);
        po({TGT_PRINTER, PP_CTRL}, 1'b1, 8'h21);
        `CHK(printer_ctrl, 8'h21)
        rd({TGT_PRINTER, PP_STATUS}, PP_STAT_VAL);
        po({TGT_SERIAL0, REG_MODEM_CTRL}, 1'b1, 8'h13);
        `CHK({send_request_n[0], terminal_ready_n[0]}, 2'b11)
        po({TGT_SERIAL0, REG_MODEM_CTRL}, 1'b1, 8'h03);
        `CHK({send_request_n[0], terminal_ready_n[0]}, 2'b00)
        axr(8'h08);
        `CHK(resp, AXI_SLVERR)
        $display("test registers done");
        aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        `CHK({send_request_n, terminal_ready_n}, 4'hF)
        `CHK(printer_data, PP_DATA_RST)
        `CHK(printer_ctrl, PP_CTRL_RST)
        rd({TGT_SERIAL0, REG_SCRATCH}, SCR_RST);
        rd({TGT_SERIAL1, REG_MODEM_STAT}, 8'h20);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
